// File: rtl/iex_defines.vh
// Constants for the instruction exception acceptance unit
`ifndef IEX_DEFINES_VH
`define IEX_DEFINES_VH

// Sequencer states
`define IEX_ST_IDLE 3'h0
`define IEX_ST_PUSH_SW 3'h1
`define IEX_ST_PUSH_PC 3'h2
`define IEX_ST_VEC_RD 3'h3
`define IEX_ST_JUMP 3'h4

// Default vector numbers for the fixed exceptions
`define IEX_VEC_GEN_ILL 8'h04
`define IEX_VEC_SLOT_ILL 8'h06
`define IEX_VEC_ADDR_ERR 8'h09

// Stack word size in bytes, one push
`define IEX_SP_STEP 32'h00000004
// Instruction size in bytes
`define IEX_INSTR_BYTES 32'h00000002
// Vector table entry shift (four bytes each)
`define IEX_VEC_SHIFT 2

// Loop length limits in instructions
`define IEX_SHORT_LOOP_MAX 32'h00000003
// Offsets back from the loop end, in bytes
`define IEX_TAIL3_OFS 32'h00000004
`define IEX_FOURTH_OFS 32'h00000006

// Exception cause codes
`define IEX_CAUSE_NONE 3'h0
`define IEX_CAUSE_TRAP 3'h1
`define IEX_CAUSE_SLOT 3'h2
`define IEX_CAUSE_GEN 3'h3
`define IEX_CAUSE_AE 3'h4
`define IEX_CAUSE_IRQ 3'h5

`endif

// File: rtl/iex_unit.v
// Instruction exception acceptance and stacking sequencer
`timescale 1ns/1ps
//
// Overview of operation
// - Push status word first, then program counter
// - Software trap stacks address after trap
// - Trap vector from instruction, no delayed jump
// - Undefined opcode in slot raises slot exception
// - PC-modifying instruction in slot raises slot exception
// - PC modifiers: delayed, conditional branches, trap
// - Slot exception stacks delayed branch target
// - Slot exception uses own vector, no delay
// - Undefined opcode outside slot: general illegal
// - General illegal handled like slot exception
// - General illegal stacks undefined opcode address
// - Refused events held pending until acceptable
// - Delay slot blocks address errors and interrupts
// - After system register access block interrupts
// - Short repeat loop blocks all events
// - Long loop: first, last three blocked
// - Long loop fourth from end: errors only
// - Zero repeat count lifts loop restrictions
// - Each stacked item is one 32-bit word
// - Stack pointer drops four per push
//
`include "iex_defines.vh"

module iex_unit (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  // Decoder side, one instruction per dec_valid
  input wire dec_valid,
  input wire [31:0] dec_addr,
  input wire [31:0] dec_next_addr,
  input wire dec_undefined,
  input wire dec_delayed_branch,
  input wire dec_cond_branch,
  input wire dec_trap,
  input wire [7:0] dec_trap_vec,
  input wire dec_sysreg_access,
  input wire [31:0] dec_branch_target,
  // Core state
  input wire [31:0] status_word,
  input wire [31:0] stack_pointer,
  input wire [31:0] vector_base,
  input wire [11:0] repeat_count,
  input wire [31:0] repeat_start,
  input wire [31:0] repeat_end,
  // Event requests, one-cycle pulses
  input wire addr_err_req,
  input wire irq_req,
  input wire [7:0] irq_vec,
  // Memory port for stacking and vector fetch
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // Results to the core
  output wire stall,
  output reg exc_start,
  output reg [2:0] exc_cause,
  output reg jump_valid,
  output reg [31:0] jump_addr,
  output reg [31:0] stack_pointer_new,
  output reg addr_err_pending,
  output reg irq_pending
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  reg [2:0] state_r; // Sequencer state
  reg [2:0] state_nxt;
  reg [2:0] cause_r; // Cause being handled
  reg [7:0] vec_r; // Vector number being handled
  reg [31:0] ret_r; // Return address to stack
  reg [31:0] sw_r; // Status word snapshot
  reg [31:0] sp_r; // Working stack pointer
  reg in_slot_r; // Next decode is a delay slot
  reg [31:0] slot_target_r; // Target of the pending delayed branch
  reg after_sys_r; // Previous decode touched system registers
  reg ae_pend_r; // Held address error
  reg irq_pend_r; // Held interrupt
  reg [7:0] irq_vec_r; // Vector of the held interrupt
  wire rc_active; // Repeat count nonzero
  wire in_loop; // Decoded address inside the loop body
  wire [31:0] loop_len; // Loop length in instructions
  wire short_loop; // Loop of one to three instructions
  wire loop_block_all; // Loop position refusing everything
  wire loop_ae_only; // Loop position taking errors only
  wire pc_modifier; // Instruction rewrites the program counter
  wire ae_ok; // Address error may be taken here
  wire irq_ok; // Interrupt may be taken here
  wire ae_now; // Address error seen this cycle
  wire irq_now; // Interrupt seen this cycle
  reg [2:0] new_cause; // Cause chosen at this decode
  reg [7:0] new_vec;
  reg [31:0] new_ret;
  wire idle;

  assign idle = (state_r == `IEX_ST_IDLE);
  assign stall = !idle; // Core holds while the sequence runs
  // Held or fresh event consumed at this decode
  wire ae_take = idle && dec_valid && (new_cause == `IEX_CAUSE_AE);
  wire irq_take = idle && dec_valid && (new_cause == `IEX_CAUSE_IRQ);

  ////////////////////////////////////////////////////////////////////
  // Classification of the decoded instruction

  // Delayed branches, conditional branches and the trap
  assign pc_modifier = dec_delayed_branch | dec_cond_branch | dec_trap;

  // Repeat loop geometry
  assign rc_active = (repeat_count != 12'h000);
  assign in_loop = rc_active && (dec_addr >= repeat_start) && (dec_addr <= repeat_end);
  assign loop_len = ((repeat_end - repeat_start) >> 1) + 32'h00000001;
  assign short_loop = (loop_len <= `IEX_SHORT_LOOP_MAX);
  // Short loop refuses everything; long loop refuses first and last three
  assign loop_block_all = in_loop && (short_loop
    || (dec_addr == repeat_start)
    || (dec_addr >= repeat_end - `IEX_TAIL3_OFS));
  // Fourth from the end admits address errors only
  assign loop_ae_only = in_loop && !short_loop
    && (dec_addr == repeat_end - `IEX_FOURTH_OFS);

  // Acceptance windows at this decode
  assign ae_ok = !in_slot_r && !loop_block_all;
  assign irq_ok = !in_slot_r && !after_sys_r
    && !loop_block_all && !loop_ae_only;

  // Held or fresh events
  assign ae_now = ae_pend_r | addr_err_req;
  assign irq_now = irq_pend_r | irq_req;

  ////////////////////////////////////////////////////////////////////
  // Cause selection at decode time
  always @*
  begin
    new_cause = `IEX_CAUSE_NONE;
    new_vec = 8'h00;
    new_ret = dec_addr;
    if (in_slot_r && (dec_undefined || pc_modifier))
    begin
      // Bad slot content: return to delayed branch target
      new_cause = `IEX_CAUSE_SLOT;
      new_vec = `IEX_VEC_SLOT_ILL;
      new_ret = slot_target_r;
    end
    else if (dec_undefined && !in_slot_r)
    begin
      // Undefined opcode elsewhere: return to itself
      new_cause = `IEX_CAUSE_GEN;
      new_vec = `IEX_VEC_GEN_ILL;
      new_ret = dec_addr;
    end
    else if (ae_now && ae_ok)
    begin
      // Address error taken before this instruction
      new_cause = `IEX_CAUSE_AE;
      new_vec = `IEX_VEC_ADDR_ERR;
      new_ret = dec_addr;
    end
    else if (irq_now && irq_ok)
    begin
      // Interrupt taken before this instruction
      new_cause = `IEX_CAUSE_IRQ;
      new_vec = irq_pend_r ? irq_vec_r : irq_vec;
      new_ret = dec_addr;
    end
    else if (dec_trap && !in_slot_r)
    begin
      // Trap: vector from the instruction, return after it
      new_cause = `IEX_CAUSE_TRAP;
      new_vec = dec_trap_vec;
      new_ret = dec_next_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `IEX_ST_IDLE:
      begin
        // Start when a cause is chosen at a decode
        if (dec_valid && (new_cause != `IEX_CAUSE_NONE))
          state_nxt = `IEX_ST_PUSH_SW;
      end
      `IEX_ST_PUSH_SW:
      begin
        // Status word goes first
        if (mem_ack)
          state_nxt = `IEX_ST_PUSH_PC;
      end
      `IEX_ST_PUSH_PC:
      begin
        // Then the return address
        if (mem_ack)
          state_nxt = `IEX_ST_VEC_RD;
      end
      `IEX_ST_VEC_RD:
      begin
        // Fetch handler address from the table
        if (mem_ack)
          state_nxt = `IEX_ST_JUMP;
      end
      `IEX_ST_JUMP:
        state_nxt = `IEX_ST_IDLE;
      default:
        state_nxt = `IEX_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer registers and memory port
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_r <= `IEX_ST_IDLE;
      cause_r <= `IEX_CAUSE_NONE;
      vec_r <= 8'h00;
      ret_r <= 32'h00000000;
      sw_r <= 32'h00000000;
      sp_r <= 32'h00000000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      exc_start <= 1'b0;
      exc_cause <= `IEX_CAUSE_NONE;
      jump_valid <= 1'b0;
      jump_addr <= 32'h00000000;
      stack_pointer_new <= 32'h00000000;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      exc_start <= 1'b0;
      jump_valid <= 1'b0;
      case (state_r)
        `IEX_ST_IDLE:
        begin
          if (state_nxt == `IEX_ST_PUSH_SW)
          begin
            // Snapshot and issue the first push
            cause_r <= new_cause;
            vec_r <= new_vec;
            ret_r <= new_ret;
            sw_r <= status_word;
            sp_r <= stack_pointer - `IEX_SP_STEP;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= stack_pointer - `IEX_SP_STEP;
            mem_wdata <= status_word;
            exc_start <= 1'b1;
            exc_cause <= new_cause;
          end
        end
        `IEX_ST_PUSH_SW:
        begin
          if (mem_ack)
          begin
            // Second push, one more word down
            sp_r <= sp_r - `IEX_SP_STEP;
            mem_addr <= sp_r - `IEX_SP_STEP;
            mem_wdata <= ret_r;
          end
        end
        `IEX_ST_PUSH_PC:
        begin
          if (mem_ack)
          begin
            // Read the vector table entry
            mem_we <= 1'b0;
            mem_wdata <= 32'h00000000;
            mem_addr <= vector_base + ({24'h000000, vec_r} << `IEX_VEC_SHIFT);
          end
        end
        `IEX_ST_VEC_RD:
        begin
          if (mem_ack)
          begin
            // Direct jump, no delay slot follows
            mem_req <= 1'b0;
            jump_addr <= mem_rdata;
            stack_pointer_new <= sp_r;
          end
        end
        `IEX_ST_JUMP:
          jump_valid <= 1'b1;
        default:
          mem_req <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode history: delay slot and system register tracking
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      in_slot_r <= 1'b0;
      slot_target_r <= 32'h00000000;
      after_sys_r <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r == `IEX_ST_JUMP)
      begin
        // Handler entry clears the history before the next decode
        in_slot_r <= 1'b0;
        after_sys_r <= 1'b0;
      end
      else if (dec_valid && idle && (new_cause == `IEX_CAUSE_NONE))
      begin
        // Branch and slot stay together
        in_slot_r <= dec_delayed_branch && !in_slot_r;
        if (dec_delayed_branch)
          slot_target_r <= dec_branch_target;
        after_sys_r <= dec_sysreg_access;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pending events: a new request wins over the acceptance clear
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ae_pend_r <= 1'b0;
      irq_pend_r <= 1'b0;
      irq_vec_r <= 8'h00;
    end
    else if (ce)
    begin
      // A fresh request taken at once is not held a second time
      if (addr_err_req && !(ae_take && !ae_pend_r))
        ae_pend_r <= 1'b1;
      else if (ae_take)
        ae_pend_r <= 1'b0;
      if (irq_req && !(irq_take && !irq_pend_r))
      begin
        irq_pend_r <= 1'b1;
        irq_vec_r <= irq_vec;
      end
      else if (irq_take)
        irq_pend_r <= 1'b0;
    end
  end

  // Held flags shown to the core
  always @*
  begin
    addr_err_pending = ae_pend_r;
    irq_pending = irq_pend_r;
  end

endmodule // iex_unit

// File: bench/iex_unit_properties.sv
// Checker for the exception unit ports
`timescale 1ns/1ps
`include "iex_defines.vh"
module iex_unit_properties (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire dec_valid,
  input wire dec_undefined,
  input wire dec_trap,
  input wire irq_req,
  input wire addr_err_req,
  input wire mem_req,
  input wire mem_we,
  input wire mem_ack,
  input wire stall,
  input wire exc_start,
  input wire jump_valid,
  input wire irq_pending,
  input wire addr_err_pending,
  input wire [31:0] stack_pointer,
  input wire [31:0] status_word,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [31:0] stack_pointer_new,
  input wire [2:0] exc_cause
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // Status word write, one word below the stack top
  sequence s_sw;
    mem_req && mem_we && mem_addr == stack_pointer - 32'h4 && mem_wdata == status_word;
  endsequence
  // Return address write, two words below
  sequence s_pc;
    mem_req && mem_we && mem_addr == stack_pointer - 32'h8;
  endsequence
  property p_first;
    exc_start |-> stall ##0 s_sw;
  endproperty
  a_first: assert property (p_first) else $error("status word not first");
  property p_second;
    s_sw ##0 (ce && mem_ack) |=> s_pc;
  endproperty
  a_second: assert property (p_second) else $error("return push missing");
  property p_vec;
    s_pc ##0 (ce && mem_ack) |=> mem_req && !mem_we;
  endproperty
  a_vec: assert property (p_vec) else $error("vector read missing");
  property p_trap;
    ce && dec_valid && !stall && dec_trap && !dec_undefined && !irq_pending
      && !addr_err_pending && !irq_req && !addr_err_req
      |=> exc_start && (exc_cause == `IEX_CAUSE_TRAP || exc_cause == `IEX_CAUSE_SLOT);
  endproperty
  a_trap: assert property (p_trap) else $error("trap not started");
  property p_undef;
    ce && dec_valid && !stall && dec_undefined
      |=> exc_start && (exc_cause == `IEX_CAUSE_SLOT || exc_cause == `IEX_CAUSE_GEN);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined not raised");
  property p_sp;
    jump_valid |-> stack_pointer_new == stack_pointer - 32'h8;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer wrong");
  property p_bound;
    exc_start |-> ##[2:40] jump_valid;
  endproperty
  a_bound: assert property (p_bound) else $error("no handler jump");
  property p_irq;
    ce && irq_req |=> irq_pending || (exc_start && exc_cause == `IEX_CAUSE_IRQ);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not held");
  property p_ae;
    ce && addr_err_req |=> addr_err_pending || (exc_start && exc_cause == `IEX_CAUSE_AE);
  endproperty
  a_ae: assert property (p_ae) else $error("address error not held");
endmodule // iex_unit_properties
bind iex_unit iex_unit_properties i_iex_unit_properties (.core_clk, .nrst, .ce, .dec_valid,
  .dec_undefined, .dec_trap, .irq_req, .addr_err_req, .mem_req, .mem_we, .mem_ack, .stall,
  .exc_start, .jump_valid, .irq_pending, .addr_err_pending, .stack_pointer, .status_word,
  .mem_addr, .mem_wdata, .stack_pointer_new, .exc_cause);

// File: bench/tb.sv
// Self-checking bench for the exception unit
`timescale 1ns/1ps
`include "iex_defines.vh"
module tb;
  localparam [31:0] SP = 32'h1000;
  localparam [31:0] SW = 32'hf0;
  localparam [31:0] VB = 32'h400;
  localparam [31:0] HND = 32'h2000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic dec_valid = 1'b0;
  logic [31:0] dec_addr = 32'h0;
  // Flags: undef, delayed, cond, trap, sysreg, irq, addr err
  logic [6:0] fl = 7'h0;
  logic [11:0] repeat_count = 12'h0;
  logic [31:0] repeat_start = 32'h0;
  logic [31:0] repeat_end = 32'h0;
  logic mem_ack = 1'b0;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer i;
  wire mem_req, mem_we, stall, exc_start, jump_valid, addr_err_pending, irq_pending;
  wire [31:0] mem_addr, mem_wdata, jump_addr, stack_pointer_new;
  wire [2:0] exc_cause;
  iex_unit i_iex_unit (.core_clk(core_clk), .nrst(nrst), .ce(ce), .dec_valid(dec_valid),
    .dec_addr(dec_addr), .dec_next_addr(dec_addr + 32'h2), .dec_undefined(fl[0]),
    .dec_delayed_branch(fl[1]), .dec_cond_branch(fl[2]), .dec_trap(fl[3]),
    .dec_trap_vec(8'h21), .dec_sysreg_access(fl[4]), .dec_branch_target(dec_addr + 32'h100),
    .status_word(SW), .stack_pointer(SP), .vector_base(VB), .repeat_count(repeat_count),
    .repeat_start(repeat_start), .repeat_end(repeat_end), .addr_err_req(fl[6]),
    .irq_req(fl[5]), .irq_vec(8'h40), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_ack ? HND : ~HND), .stall(stall), .exc_start(exc_start),
    .exc_cause(exc_cause), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .stack_pointer_new(stack_pointer_new), .addr_err_pending(addr_err_pending),
    .irq_pending(irq_pending));
  ////////////////////////////////////////////////////////////////
  always #4 core_clk = ~core_clk;
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One decode, held for one taken edge
  task dec(input [31:0] a, input [6:0] f);
    @(posedge core_clk);
    dec_valid <= 1'b1;
    dec_addr <= a;
    fl <= f;
    @(posedge core_clk);
    dec_valid <= 1'b0;
    fl <= 7'h0;
    #1;
  endtask
  // One memory step, acked after it is seen
  task mem(input w, input [31:0] ad, input [31:0] wd);
    repeat (20) if (mem_req !== 1'b1) begin @(posedge core_clk); #1; end
    chk(mem_we, w);
    chk(mem_addr, ad);
    if (w) chk(mem_wdata, wd);
    @(posedge core_clk) mem_ack <= 1'b1;
    @(posedge core_clk) mem_ack <= 1'b0;
    #1;
  endtask
  // Full exception sequence with its stack and vector
  task exc(input [2:0] c, input [31:0] ret, input [7:0] v);
    chk(exc_start, 1'b1);
    chk(exc_cause, c);
    mem(1'b1, SP - 32'h4, SW);
    mem(1'b1, SP - 32'h8, ret);
    mem(1'b0, VB + {22'h0, v, 2'h0}, 32'h0);
    repeat (20) if (stall !== 1'b0) begin @(posedge core_clk); #1; end
    chk(jump_addr, HND);
    chk(stack_pointer_new, SP - 32'h8);
  endtask
  task t_instr;
    dec(32'h200, 7'h08);
    exc(`IEX_CAUSE_TRAP, 32'h202, 8'h21);
    for (i = 0; i < 4; i++)
    begin
      dec(32'h300, 7'h02);
      dec(32'h302, 7'h01 << i);
      exc(`IEX_CAUSE_SLOT, 32'h400, `IEX_VEC_SLOT_ILL);
    end
    dec(32'h500, 7'h01);
    exc(`IEX_CAUSE_GEN, 32'h500, `IEX_VEC_GEN_ILL);
    $display("instruction test done");
  endtask
  task t_events;
    dec(32'h600, 7'h10);
    dec(32'h602, 7'h20);
    chk(exc_start, 1'b0);
    chk(irq_pending, 1'b1);
    dec(32'h604, 7'h00);
    exc(`IEX_CAUSE_IRQ, 32'h604, 8'h40);
    chk(irq_pending, 1'b0);
    dec(32'h606, 7'h10);
    dec(32'h608, 7'h40);
    exc(`IEX_CAUSE_AE, 32'h608, `IEX_VEC_ADDR_ERR);
    chk(addr_err_pending, 1'b0);
    dec(32'h610, 7'h02);
    dec(32'h612, 7'h20);
    chk(exc_start, 1'b0);
    chk(irq_pending, 1'b1);
    dec(32'h710, 7'h00);
    exc(`IEX_CAUSE_IRQ, 32'h710, 8'h40);
    $display("event test done");
  endtask
  task t_loop;
    @(posedge core_clk);
    repeat_count <= 12'h1;
    repeat_start <= 32'h800;
    repeat_end <= 32'h804;
    dec(32'h802, 7'h20);
    chk(exc_start, 1'b0);
    @(posedge core_clk);
    repeat_end <= 32'h80e;
    dec(32'h80c, 7'h40);
    chk(exc_start, 1'b0);
    dec(32'h808, 7'h00);
    exc(`IEX_CAUSE_AE, 32'h808, `IEX_VEC_ADDR_ERR);
    dec(32'h800, 7'h00);
    chk(exc_start, 1'b0);
    @(posedge core_clk);
    repeat_count <= 12'h0;
    dec(32'h802, 7'h00);
    exc(`IEX_CAUSE_IRQ, 32'h802, 8'h40);
    $display("loop test done");
  endtask
  // Clock enable low freezes the sequence, acks included
  task t_freeze;
    dec(32'h900, 7'h08);
    @(posedge core_clk);
    ce <= 1'b0;
    mem_ack <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(mem_addr, SP - 32'h4);
    chk(stall, 1'b1);
    @(posedge core_clk);
    ce <= 1'b1;
    mem_ack <= 1'b0;
    #1;
    mem(1'b1, SP - 32'h4, SW);
    mem(1'b1, SP - 32'h8, 32'h902);
    mem(1'b0, VB + {22'h0, 8'h21, 2'h0}, 32'h0);
    repeat (20) if (stall !== 1'b0) begin @(posedge core_clk); #1; end
    chk(jump_addr, HND);
    $display("freeze test done");
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_instr;
    t_events;
    t_loop;
    t_freeze;
    conclude;
  end
  // Watchdog against a hung sequence
  initial
  begin
    #40000;
    n_errors++;
    conclude;
  end
endmodule // tb
